/* File: omc_map.vh */
// Constants for the operating mode controller: register map, field
// positions, reset values, mode codes, debug command codes and vectors.
// Assumes inclusion by bare name from the design files.
`ifndef OMC_MAP_VH
`define OMC_MAP_VH

// Register byte offsets on the APB slave
`define OMC_CTRL_OFS 12'h000
`define OMC_STAT_OFS 12'h004
`define OMC_PORT_OFS 12'h008

// Control register fields
`define OMC_STOP_EN_BIT 0
`define OMC_PD_SEL_BIT 1
`define OMC_LVD_EN_BIT 2
`define OMC_LVD_STOP_BIT 3
`define OMC_ACK_BIT 4
`define OMC_IRQ_HI_BIT 5
`define OMC_CTRL_W 6
`define OMC_CTRL_RST 6'h00
`define OMC_PORT_RST 8'h00
// Edges after reset before the synchronised mode pin is trusted
`define OMC_SYNC_SETTLE 2'h2

// Status register fields
`define OMC_ST_MODE_LSB 0
`define OMC_ST_FLAG_BIT 4
`define OMC_ST_LATCH_BIT 5

// Operating modes
`define OMC_M_RST 3'h0
`define OMC_M_RUN 3'h1
`define OMC_M_DBG 3'h2
`define OMC_M_WAIT 3'h3
`define OMC_M_STOP2 3'h4
`define OMC_M_STOP3 3'h5

// Debug command classes
`define OMC_C_MEM 3'h0
`define OMC_C_MEM_STAT 3'h1
`define OMC_C_DBG_REG 3'h2
`define OMC_C_BACKGROUND 3'h3
`define OMC_C_CPU_REG 3'h4
`define OMC_C_TRACE 3'h5
`define OMC_C_GO 3'h6

// Vector addresses (high byte location)
`define OMC_V_RESET 16'hfffe
`define OMC_V_LVD 16'hfffa
`define OMC_V_IRQ 16'hfff8
`define OMC_V_KBI 16'hffda
`define OMC_V_ADC 16'hffd8
`define OMC_V_RTI 16'hffd0

`endif

/* File: omc_sync.v */
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to ref_clk.
`default_nettype none

module omc_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input wire ref_clk,
  input wire srst,
  // Data
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // The first stage feeds only the second
  always @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // omc_sync

`default_nettype wire

/* File: omc_mode_ctrl.v */
// Operating mode controller: run, debug, wait and two stop modes,
// debug command admission, wake-up and vectors, pin-state latching.
// Assumes CPU and debug-controller strobes arrive on ref_clk as
// one-cycle pulses; mode, reset and interrupt pins are asynchronous.
//
// The register offsets and register access over APB are this design's own decisions.
`include "omc_map.vh"
`default_nettype none

module omc_mode_ctrl #(
  parameter PIN_W = 6
) (
  // Clock and reset
  input wire ref_clk,
  input wire srst,
  // Pins
  input wire debug_mode_select_pin,
  input wire reset_pin_n,
  input wire irq_pin,
  // CPU events
  input wire cpu_wait_exec,
  input wire cpu_stop_exec,
  input wire enter_debug_instruction,
  input wire debug_breakpoint_hit,
  // Interrupt sources
  input wire int_periodic_wakeup_timer,
  input wire int_low_voltage_detector,
  input wire int_adc,
  input wire int_keypad_interrupt_unit,
  // Debug command from the serial debug logic
  input wire dbg_cmd_valid,
  input wire [2:0] dbg_cmd,
  // Peripheral pin control
  input wire [PIN_W-1:0] periph_en,
  input wire [PIN_W-1:0] periph_out,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // CPU control
  output reg [2:0] mode_q,
  output reg cpu_reset_q,
  output reg cpu_clk_en_q,
  output reg cpu_suspend_q,
  output reg cpu_step_q,
  output reg ccr_mask_clear_q,
  output reg cpu_stack_q,
  output reg vector_load_q,
  output reg [15:0] vector_q,
  output reg illegal_op_reset_q,
  output reg periph_reset_q,
  output reg clocks_halt_q,
  output reg powerdown_q,
  // Debug command answer
  output reg dbg_accept_q,
  output reg dbg_reject_q,
  output reg dbg_stat_err_q,
  // Pins
  output reg [PIN_W-1:0] pin_out_q
);

  wire ms_s;
  wire rst_pin_s_n;
  wire irq_s;

  omc_sync #(
    .W(3),
    .RST_VAL(3'b111)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in({irq_pin, reset_pin_n, debug_mode_select_pin}),
    .sync_out({irq_s, rst_pin_s_n, ms_s})
  );

  reg [`OMC_CTRL_W-1:0] ctrl_q;
  reg [PIN_W-1:0] port_q;
  reg powerdown_wake_flag_q;
  reg latched_q;
  reg [PIN_W-1:0] hold_q;
  reg [1:0] settle_q;
  localparam [7:0] PORT_RST = `OMC_PORT_RST;

  wire stop_enable_bit = ctrl_q[`OMC_STOP_EN_BIT];
  wire partial_powerdown_select = ctrl_q[`OMC_PD_SEL_BIT];
  wire low_voltage_detect_enable = ctrl_q[`OMC_LVD_EN_BIT];
  wire low_voltage_in_stop_enable = ctrl_q[`OMC_LVD_STOP_BIT];
  wire irq_hi = ctrl_q[`OMC_IRQ_HI_BIT];

  // APB decode
  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pready_q & pwrite;
  wire hit_ctrl = (paddr == `OMC_CTRL_OFS);
  wire hit_stat = (paddr == `OMC_STAT_OFS);
  wire hit_port = (paddr == `OMC_PORT_OFS);
  wire hit_any = hit_ctrl | hit_stat | hit_port;
  wire ctrl_wr = wr_go & hit_ctrl;
  wire powerdown_release_ack = ctrl_wr & pwdata[`OMC_ACK_BIT];

  // Interrupt level as configured, outside power-down
  wire irq_act = irq_hi ? irq_s : ~irq_s;
  wire any_int = int_low_voltage_detector | irq_act | int_keypad_interrupt_unit |
                 int_adc | int_periodic_wakeup_timer;

  // Priority follows vector address: highest location wins
  reg [15:0] int_vec;
  always @* begin
    if (int_low_voltage_detector) begin
      int_vec = `OMC_V_LVD;
    end else if (irq_act) begin
      int_vec = `OMC_V_IRQ;
    end else if (int_keypad_interrupt_unit) begin
      int_vec = `OMC_V_KBI;
    end else if (int_adc) begin
      int_vec = `OMC_V_ADC;
    end else begin
      int_vec = `OMC_V_RTI;
    end
  end

  // Debug command admission per mode
  wire cmd_nonintr = (dbg_cmd == `OMC_C_MEM) | (dbg_cmd == `OMC_C_MEM_STAT) |
                     (dbg_cmd == `OMC_C_DBG_REG) | (dbg_cmd == `OMC_C_BACKGROUND);
  wire cmd_active = (dbg_cmd == `OMC_C_CPU_REG) | (dbg_cmd == `OMC_C_TRACE) |
                    (dbg_cmd == `OMC_C_GO);
  reg cmd_ok;
  always @* begin
    case (mode_q)
      `OMC_M_RUN: cmd_ok = cmd_nonintr;
      `OMC_M_DBG: cmd_ok = cmd_nonintr | cmd_active;
      `OMC_M_WAIT: cmd_ok = (dbg_cmd == `OMC_C_BACKGROUND) |
                            (dbg_cmd == `OMC_C_MEM_STAT);
      default: cmd_ok = 1'b0;
    endcase
  end
  wire cmd_go = dbg_cmd_valid & cmd_ok;
  wire cmd_bg = cmd_go & (dbg_cmd == `OMC_C_BACKGROUND);

  // Stop choice: power-down only when nothing needs the regulator
  wire lvd_in_stop = low_voltage_detect_enable & low_voltage_in_stop_enable;
  wire pick_stop2 = partial_powerdown_select & stop_enable_bit & ~lvd_in_stop;

  // Power-down exit sources; the interrupt pin counts as active low
  wire stop2_wake = ~irq_s | int_periodic_wakeup_timer;

  // Mode sequencer
  reg [2:0] mode_d;
  reg int_reset;
  reg wake_pd;
  reg enter_pd;
  always @* begin
    mode_d = mode_q;
    int_reset = 1'b0;
    wake_pd = 1'b0;
    enter_pd = 1'b0;
    if (~rst_pin_s_n) begin
      mode_d = `OMC_M_RST;
      int_reset = 1'b1;
    end else begin
      case (mode_q)
        `OMC_M_RST: begin
          if (settle_q == `OMC_SYNC_SETTLE) begin
            mode_d = ms_s ? `OMC_M_RUN : `OMC_M_DBG;
          end
        end
        `OMC_M_RUN: begin
          if (enter_debug_instruction | debug_breakpoint_hit | cmd_bg) begin
            mode_d = `OMC_M_DBG;
          end else if (cpu_wait_exec) begin
            mode_d = `OMC_M_WAIT;
          end else if (cpu_stop_exec & ~stop_enable_bit) begin
            mode_d = `OMC_M_RST;
            int_reset = 1'b1;
          end else if (cpu_stop_exec) begin
            mode_d = pick_stop2 ? `OMC_M_STOP2 : `OMC_M_STOP3;
            enter_pd = pick_stop2;
          end
        end
        `OMC_M_DBG: begin
          if (cmd_go & (dbg_cmd == `OMC_C_GO)) begin
            mode_d = `OMC_M_RUN;
          end
        end
        `OMC_M_WAIT: begin
          if (cmd_bg) begin
            mode_d = `OMC_M_DBG;
          end else if (any_int) begin
            mode_d = `OMC_M_RUN;
          end
        end
        `OMC_M_STOP2: begin
          if (stop2_wake) begin
            mode_d = `OMC_M_RST;
            int_reset = 1'b1;
            wake_pd = 1'b1;
          end
        end
        `OMC_M_STOP3: begin
          if (any_int) begin
            mode_d = `OMC_M_RUN;
          end
        end
        default: begin
          mode_d = `OMC_M_RST;
          int_reset = 1'b1;
        end
      endcase
    end
  end

  wire leave_to_int = (mode_d == `OMC_M_RUN) &
                      ((mode_q == `OMC_M_WAIT) | (mode_q == `OMC_M_STOP3));

  always @(posedge ref_clk) begin
    if (srst) begin
      mode_q <= `OMC_M_RST;
      cpu_reset_q <= 1'b1;
      cpu_clk_en_q <= 1'b0;
      cpu_suspend_q <= 1'b0;
      cpu_step_q <= 1'b0;
      ccr_mask_clear_q <= 1'b0;
      cpu_stack_q <= 1'b0;
      vector_load_q <= 1'b0;
      vector_q <= `OMC_V_RESET;
      illegal_op_reset_q <= 1'b0;
      periph_reset_q <= 1'b1;
      clocks_halt_q <= 1'b0;
      powerdown_q <= 1'b0;
      dbg_accept_q <= 1'b0;
      dbg_reject_q <= 1'b0;
      dbg_stat_err_q <= 1'b0;
      settle_q <= 2'h0;
    end else begin
      mode_q <= mode_d;
      if (settle_q != `OMC_SYNC_SETTLE) begin
        settle_q <= settle_q + 2'h1;
      end
      cpu_reset_q <= (mode_d == `OMC_M_RST);
      // CPU clock runs in run and debug modes; debug holds it suspended
      cpu_clk_en_q <= (mode_d == `OMC_M_RUN) | (mode_d == `OMC_M_DBG);
      cpu_suspend_q <= (mode_d == `OMC_M_DBG);
      cpu_step_q <= cmd_go & (dbg_cmd == `OMC_C_TRACE) & (mode_q == `OMC_M_DBG);
      ccr_mask_clear_q <= (mode_d == `OMC_M_WAIT) & (mode_q != `OMC_M_WAIT);
      cpu_stack_q <= leave_to_int;
      vector_load_q <= leave_to_int | ((mode_q == `OMC_M_RST) & (mode_d != `OMC_M_RST));
      if (leave_to_int) begin
        vector_q <= int_vec;
      end else if (mode_q == `OMC_M_RST) begin
        vector_q <= `OMC_V_RESET;
      end
      illegal_op_reset_q <= (mode_q == `OMC_M_RUN) & cpu_stop_exec &
                            ~stop_enable_bit & rst_pin_s_n;
      periph_reset_q <= int_reset;
      // Both stops halt clocks; retention stop only freezes, state untouched
      clocks_halt_q <= (mode_d == `OMC_M_STOP2) | (mode_d == `OMC_M_STOP3);
      powerdown_q <= (mode_d == `OMC_M_STOP2);
      dbg_accept_q <= cmd_go;
      dbg_reject_q <= dbg_cmd_valid & ~cmd_ok;
      dbg_stat_err_q <= cmd_go & (mode_q == `OMC_M_WAIT) &
                        (dbg_cmd == `OMC_C_MEM_STAT);
    end
  end

  // Registers; internal resets return them to defaults like power-on
  always @(posedge ref_clk) begin
    if (srst | int_reset) begin
      ctrl_q <= `OMC_CTRL_RST;
      port_q <= PORT_RST[PIN_W-1:0];
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= pwdata[`OMC_CTRL_W-1:0] & ~(`OMC_CTRL_W'h1 << `OMC_ACK_BIT);
      end
      if (wr_go & hit_port) begin
        port_q <= pwdata[PIN_W-1:0];
      end
    end
  end

  // Flag and latches survive wake; only true power-on or an acknowledge clears them
  always @(posedge ref_clk) begin
    if (srst) begin
      powerdown_wake_flag_q <= 1'b0;
      latched_q <= 1'b0;
      hold_q <= {PIN_W{1'b0}};
    end else begin
      // Wake wins over a same-cycle acknowledge
      if (wake_pd) begin
        powerdown_wake_flag_q <= 1'b1;
      end else if (powerdown_release_ack) begin
        powerdown_wake_flag_q <= 1'b0;
      end
      if (enter_pd) begin
        latched_q <= 1'b1;
        hold_q <= pin_out_q;
      end else if (powerdown_release_ack & ~powerdown_q) begin
        latched_q <= 1'b0;
      end
    end
  end

  // Pin drivers
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_pin
      always @(posedge ref_clk) begin
        if (srst) begin
          pin_out_q[gi] <= 1'b0;
        end else if (latched_q | enter_pd) begin
          pin_out_q[gi] <= latched_q ? hold_q[gi] : pin_out_q[gi];
        end else begin
          pin_out_q[gi] <= periph_en[gi] ? periph_out[gi] : port_q[gi];
        end
      end
    end
  endgenerate

  // APB answer: one wait-free access phase after each setup
  always @(posedge ref_clk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      prdata_q <= 32'h0000_0000;
      if (setup & ~pwrite & hit_ctrl) begin
        prdata_q[`OMC_CTRL_W-1:0] <= ctrl_q; // acknowledge reads zero
      end else if (setup & ~pwrite & hit_stat) begin
        prdata_q[`OMC_ST_MODE_LSB+2:`OMC_ST_MODE_LSB] <= mode_q;
        prdata_q[`OMC_ST_FLAG_BIT] <= powerdown_wake_flag_q;
        prdata_q[`OMC_ST_LATCH_BIT] <= latched_q;
      end else if (setup & ~pwrite & hit_port) begin
        prdata_q[PIN_W-1:0] <= port_q;
      end
    end
  end

endmodule // omc_mode_ctrl

`default_nettype wire

/* File: omc_cpu_model.sv */
// CPU core and debug host stand-in: issues one-cycle CPU event pulses
// and debug commands. Assumes a single ref_clk domain.
`default_nettype none
module omc_cpu_model (
  // Clock
  input wire logic ref_clk,
  // CPU events
  output var logic wait_ex,
  output var logic stop_ex,
  output var logic bg_ins,
  output var logic bkpt,
  // Debug command
  output var logic cmd_v,
  output var logic [2:0] cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wait_ex, stop_ex, bg_ins, bkpt, cmd_v} = 5'h00;
    cmd = 3'h0;
  end
  // 0 wait, 1 stop, 2 debug instruction, 3 breakpoint
  task ev(input int k);
    @(posedge ref_clk);
    {bkpt, bg_ins, stop_ex, wait_ex} <= 4'h1 << k;
    @(posedge ref_clk);
    {bkpt, bg_ins, stop_ex, wait_ex} <= 4'h0;
  endtask
  task send(input logic [2:0] c);
    @(posedge ref_clk);
    cmd_v <= 1'b1;
    cmd <= c;
    @(posedge ref_clk);
    cmd_v <= 1'b0;
    // Idle code is scrambled so a stale value is never mistaken for a command
    cmd <= ~c;
  endtask
endmodule // omc_cpu_model
`default_nettype wire

/* File: omc_monitor.sv */
// Checker for the mode controller; sees only top-level ports.
// Assumes ref_clk single domain and synchronous srst.
`include "omc_map.vh"
`default_nettype none
module omc_monitor #(
  parameter PIN_W = 6
) (
  // Clock and reset
  input wire ref_clk,
  input wire srst,
  // Inputs watched
  input wire psel,
  input wire penable,
  input wire dbg_cmd_valid,
  input wire [2:0] dbg_cmd,
  // Outputs watched
  input wire pready_q,
  input wire [2:0] mode_q,
  input wire cpu_suspend_q,
  input wire cpu_clk_en_q,
  input wire ccr_mask_clear_q,
  input wire clocks_halt_q,
  input wire powerdown_q,
  input wire dbg_accept_q,
  input wire dbg_reject_q,
  input wire dbg_stat_err_q,
  input wire [PIN_W-1:0] pin_out_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire in_wait = mode_q == `OMC_M_WAIT;
  dbg_answer_a: assert property (dbg_cmd_valid |=> dbg_accept_q ^ dbg_reject_q)
    else $error("debug command not answered once");
  run_active_a: assert property (dbg_cmd_valid && mode_q == `OMC_M_RUN && dbg_cmd[2]
    |=> dbg_reject_q) else $error("active command taken in run");
  wait_refuse_a: assert property (dbg_cmd_valid && in_wait && !dbg_cmd[0]
    |=> dbg_reject_q) else $error("command taken in wait");
  wait_status_a: assert property (dbg_cmd_valid && in_wait && dbg_cmd == `OMC_C_MEM_STAT
    |=> dbg_accept_q && dbg_stat_err_q) else $error("status error missing in wait");
  wait_wake_a: assert property (dbg_cmd_valid && in_wait && dbg_cmd == `OMC_C_BACKGROUND
    |=> mode_q == `OMC_M_DBG) else $error("background did not wake wait");
  mask_clear_a: assert property (in_wait && $past(mode_q) != `OMC_M_WAIT
    |-> ccr_mask_clear_q) else $error("mask not cleared on wait");
  wait_clock_a: assert property (in_wait |-> !cpu_clk_en_q && !clocks_halt_q)
    else $error("wait clocking wrong");
  debug_hold_a: assert property (mode_q == `OMC_M_DBG |-> cpu_suspend_q)
    else $error("cpu not suspended in debug");
  stop_halt_a: assert property (mode_q inside {`OMC_M_STOP2, `OMC_M_STOP3}
    |-> clocks_halt_q) else $error("clocks run in stop");
  pins_held_a: assert property (powerdown_q && $past(powerdown_q) |-> $stable(pin_out_q))
    else $error("pins moved in power-down");
  apb_ready_a: assert property (psel && !penable |=> pready_q)
    else $error("access phase not ready");
  cover property (mode_q == `OMC_M_STOP2);
  cover property (in_wait ##1 mode_q == `OMC_M_DBG);
  cover property (dbg_stat_err_q);
endmodule // omc_monitor
bind omc_mode_ctrl omc_monitor #(.PIN_W(PIN_W)) u_mon (.ref_clk(ref_clk), .srst(srst),
  .psel(psel), .penable(penable), .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd(dbg_cmd),
  .pready_q(pready_q), .mode_q(mode_q), .cpu_suspend_q(cpu_suspend_q),
  .cpu_clk_en_q(cpu_clk_en_q), .ccr_mask_clear_q(ccr_mask_clear_q),
  .clocks_halt_q(clocks_halt_q), .powerdown_q(powerdown_q), .dbg_accept_q(dbg_accept_q),
  .dbg_reject_q(dbg_reject_q), .dbg_stat_err_q(dbg_stat_err_q), .pin_out_q(pin_out_q));
`default_nettype wire

/* File: omc_mode_ctrl_test.sv */
// Self-checking bench for the mode controller over APB.
// Assumes the CPU model drives events and debug commands.
`include "omc_map.vh"
`default_nettype none
module omc_mode_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, srst, ms_pin, rst_n, irq_pin, i_rti, i_lvd, i_adc, i_kbi;
  logic psel, penable, pwrite;
  logic [5:0] p_en, p_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic er;
  wire logic wait_ex, stop_ex, bg_ins, bkpt, cmd_v, pready_q, pslverr_q, suspend;
  wire logic clk_en, mask_clr, stack, prst, illegal, halt, pdown, acc, rej, serr;
  wire logic creset, step, vload;
  wire logic [2:0] cmd, mode_q;
  wire logic [15:0] vector_q;
  wire logic [31:0] prdata_q;
  wire logic [5:0] pin_out_q;
  int err_total = 0;
  int cmp_count = 0;
  omc_cpu_model u_cpu (.ref_clk(ref_clk), .wait_ex(wait_ex), .stop_ex(stop_ex),
    .bg_ins(bg_ins), .bkpt(bkpt), .cmd_v(cmd_v), .cmd(cmd));
  omc_mode_ctrl #(.PIN_W(6)) dut (.ref_clk(ref_clk), .srst(srst),
    .debug_mode_select_pin(ms_pin), .reset_pin_n(rst_n), .irq_pin(irq_pin),
    .cpu_wait_exec(wait_ex), .cpu_stop_exec(stop_ex), .enter_debug_instruction(bg_ins),
    .debug_breakpoint_hit(bkpt), .int_periodic_wakeup_timer(i_rti),
    .int_low_voltage_detector(i_lvd), .int_adc(i_adc), .int_keypad_interrupt_unit(i_kbi),
    .dbg_cmd_valid(cmd_v), .dbg_cmd(cmd), .periph_en(p_en), .periph_out(p_out),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .mode_q(mode_q),
    .cpu_reset_q(creset), .cpu_clk_en_q(clk_en), .cpu_suspend_q(suspend), .cpu_step_q(step),
    .ccr_mask_clear_q(mask_clr), .cpu_stack_q(stack), .vector_load_q(vload),
    .vector_q(vector_q), .illegal_op_reset_q(illegal), .periph_reset_q(prst),
    .clocks_halt_q(halt), .powerdown_q(pdown), .dbg_accept_q(acc), .dbg_reject_q(rej),
    .dbg_stat_err_q(serr), .pin_out_q(pin_out_q));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready_q !== 1'b1);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    // Return off the edge so callers judge settled outputs
    @(negedge ref_clk);
  endtask
  // Waits at falling edges, so pulses of the arrival cycle can be judged
  task wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (mode_q !== m && n < 40);
    chk("mode", m, mode_q);
  endtask
  task cmd_chk(input logic [2:0] c, input logic a);
    u_cpu.send(c);
    @(negedge ref_clk);
    chk("accept", a, acc);
    chk("reject", !a, rej);
  endtask
  task sc_debug;
    u_cpu.ev(2);
    wait_mode(`OMC_M_DBG);
    chk("suspend", 1, suspend);
    for (int c = 0; c < 6; c++)
      cmd_chk(c, 1'b1);
    cmd_chk(`OMC_C_TRACE, 1'b1);
    chk("step", 1, step);
    cmd_chk(`OMC_C_GO, 1'b1);
    chk("go", `OMC_M_RUN, mode_q);
    for (int c = 0; c < 8; c++)
      if (c != 3)
        cmd_chk(c, c < 3);
    cmd_chk(`OMC_C_BACKGROUND, 1'b1);
    chk("bg", `OMC_M_DBG, mode_q);
    cmd_chk(`OMC_C_GO, 1'b1);
    u_cpu.ev(3);
    wait_mode(`OMC_M_DBG);
    cmd_chk(`OMC_C_GO, 1'b1);
  endtask
  task sc_wait;
    u_cpu.ev(0);
    wait_mode(`OMC_M_WAIT);
    chk("mask", 1, mask_clr);
    chk("clk", 0, clk_en);
    cmd_chk(`OMC_C_MEM, 1'b0);
    cmd_chk(`OMC_C_MEM_STAT, 1'b1);
    chk("stat", 1, serr);
    cmd_chk(`OMC_C_BACKGROUND, 1'b1);
    chk("wake", `OMC_M_DBG, mode_q);
    cmd_chk(`OMC_C_GO, 1'b1);
    u_cpu.ev(0);
    @(posedge ref_clk);
    i_adc <= 1'b1;
    wait_mode(`OMC_M_RUN);
    chk("stack", 1, stack);
    chk("vec", `OMC_V_ADC, vector_q);
    @(posedge ref_clk);
    i_adc <= 1'b0;
  endtask
  task sc_stops;
    u_cpu.ev(1);
    @(negedge ref_clk);
    chk("illegal", 1, illegal);
    chk("halt", 0, halt);
    wait_mode(`OMC_M_RUN);
    apb(1, `OMC_PORT_OFS, 32'h2a);
    apb(1, `OMC_CTRL_OFS, 32'h03);
    u_cpu.ev(1);
    wait_mode(`OMC_M_STOP2);
    chk("pd", 1, pdown);
    chk("pins", 6'h2a, pin_out_q);
    @(posedge ref_clk);
    irq_pin <= 1'b0;
    wait_mode(`OMC_M_RST);
    chk("prst", 1, prst);
    chk("creset", 1, creset);
    @(posedge ref_clk);
    irq_pin <= 1'b1;
    wait_mode(`OMC_M_RUN);
    chk("vload", 1, vload);
    chk("vec", `OMC_V_RESET, vector_q);
    apb(0, `OMC_STAT_OFS, 0);
    chk("flag", 2'h3, rd[5:4]);
    apb(0, `OMC_PORT_OFS, 0);
    chk("port", 0, rd);
    chk("held", 6'h2a, pin_out_q);
    apb(1, `OMC_CTRL_OFS, 32'h10);
    apb(0, `OMC_STAT_OFS, 0);
    chk("ack", 0, rd[5:4]);
    chk("pins", 0, pin_out_q);
    apb(0, `OMC_CTRL_OFS, 0);
    chk("ctrl", 0, rd);
    apb(1, `OMC_CTRL_OFS, 32'h0f);
    u_cpu.ev(1);
    wait_mode(`OMC_M_STOP3);
    chk("pd3", 0, pdown);
    @(posedge ref_clk);
    i_kbi <= 1'b1;
    wait_mode(`OMC_M_RUN);
    chk("vec", `OMC_V_KBI, vector_q);
    @(posedge ref_clk);
    i_kbi <= 1'b0;
    apb(0, `OMC_CTRL_OFS, 0);
    chk("keep", 32'h0f, rd);
    apb(0, 12'h00c, 0);
    chk("err", 1, er);
    chk("rd0", 0, rd);
  endtask
  // Power-down left by the timer, pins handed to peripherals, wait exit vectors
  task sc_wake;
    apb(1, `OMC_PORT_OFS, 32'h2a);
    apb(1, `OMC_CTRL_OFS, 32'h23);
    u_cpu.ev(1);
    wait_mode(`OMC_M_STOP2);
    repeat (4) @(negedge ref_clk);
    chk("irq_high", `OMC_M_STOP2, mode_q);
    @(posedge ref_clk);
    i_rti <= 1'b1;
    wait_mode(`OMC_M_RST);
    @(posedge ref_clk);
    i_rti <= 1'b0;
    wait_mode(`OMC_M_RUN);
    @(posedge ref_clk);
    p_en <= 6'h0f;
    apb(0, `OMC_STAT_OFS, 0);
    chk("flag", 2'h3, rd[5:4]);
    chk("held", 6'h2a, pin_out_q);
    apb(1, `OMC_CTRL_OFS, 32'h10);
    @(negedge ref_clk);
    chk("periph", 6'h05, pin_out_q);
    @(posedge ref_clk);
    p_en <= 6'h00;
    apb(1, `OMC_CTRL_OFS, 32'h20);
    u_cpu.ev(0);
    wait_mode(`OMC_M_RUN);
    chk("irq_vec", `OMC_V_IRQ, vector_q);
    apb(1, `OMC_CTRL_OFS, 32'h00);
    u_cpu.ev(0);
    @(posedge ref_clk);
    i_lvd <= 1'b1;
    i_adc <= 1'b1;
    wait_mode(`OMC_M_RUN);
    chk("lvd_vec", `OMC_V_LVD, vector_q);
    @(posedge ref_clk);
    i_lvd <= 1'b0;
    i_adc <= 1'b0;
  endtask
  // Reset pin with the mode pin low lands in debug
  task sc_pin_reset;
    @(posedge ref_clk);
    ms_pin <= 1'b0;
    rst_n <= 1'b0;
    wait_mode(`OMC_M_RST);
    chk("creset", 1, creset);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_mode(`OMC_M_DBG);
    chk("vload", 1, vload);
    chk("rvec", `OMC_V_RESET, vector_q);
    @(posedge ref_clk);
    ms_pin <= 1'b1;
    cmd_chk(`OMC_C_GO, 1'b1);
    chk("run", `OMC_M_RUN, mode_q);
  endtask
  initial begin
    {srst, ms_pin, rst_n, irq_pin} = 4'hf;
    {i_rti, i_lvd, i_adc, i_kbi, psel, penable, pwrite} = 7'h00;
    p_en = 6'h00;
    p_out = 6'h15;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    wait_mode(`OMC_M_RUN);
    chk("vec", `OMC_V_RESET, vector_q);
    sc_debug();
    sc_wait();
    sc_stops();
    sc_wake();
    sc_pin_reset();
    complete_run();
  end
  initial begin
    #(50 * 20000);
    err_total++;
    complete_run();
  end
endmodule // omc_mode_ctrl_test
`default_nettype wire
